// *** inc/srr_params.svh ***
/*
 * Constants for the return and rotate execution block: opcode patterns,
 * field positions, flag positions, address limits and reset values.
 * Assumes it is included by its bare name from the package or from the design.
 */
`ifndef SRR_PARAMS_SVH
`define SRR_PARAMS_SVH

// Opcode patterns (instruction word is 16 bits)
`define SRR_RET_PATTERN 15'h0009
`define SRR_ROT_PATTERN 6'h0D
`define SRR_RET_OP_MSB 15
`define SRR_RET_OP_LSB 1
`define SRR_ROT_OP_MSB 15
`define SRR_ROT_OP_LSB 10

// Operand field positions
`define SRR_SEL_BIT 0
`define SRR_DEST_BIT 9
`define SRR_ACC_BIT 8
`define SRR_FILE_MSB 7
`define SRR_FILE_LSB 0

// Flag positions inside the status register
`define SRR_FLAG_C 0
`define SRR_FLAG_Z 2
`define SRR_FLAG_N 4

// Operand addressing
`define SRR_IDX_LIMIT 8'h5F
`define SRR_ACCESS_HIGH_BANK 4'hF

// Reset values
`define SRR_PC_RESET 21'h000000
`define SRR_BYTE_RESET 8'h00
`define SRR_BSR_RESET 4'h0
`define SRR_ADDR_RESET 12'h000
`define SRR_INSTR_RESET 16'h0000

`endif

// *** inc/srr_pkg.sv ***
/*
 * Types shared by the return and rotate execution block.
 * Assumes the constants header sits on the include path.
 */
package srr_pkg;
	`include "srr_params.svh"

	// Instruction clock phases, one-hot
	typedef enum logic [3:0] {
		SRR_Q1 = 4'h1,
		SRR_Q2 = 4'h2,
		SRR_Q3 = 4'h4,
		SRR_Q4 = 4'h8
	} srr_phase_type;

	// Operation held for the current instruction cycle, one-hot
	typedef enum logic [3:0] {
		SRR_OP_NONE = 4'h1,
		SRR_OP_RET = 4'h2,
		SRR_OP_ROT = 4'h4,
		SRR_OP_FLUSH = 4'h8
	} srr_op_type;

	// Shadow copies restored by a fast return
	typedef struct packed {
		logic [7:0] working;
		logic [7:0] flags;
		logic [3:0] bank;
	} srr_shadow_type;

	// Write request toward the file register memory
	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} srr_file_wr_type;
endpackage : srr_pkg

// *** sim/srr_core_asserts.sv ***
/* Checker for the return and rotate block: timing and data of both operations.
 * Assumes it is bound to srr_core and sees only that module's ports. */
`timescale 1ns/1ns
`include "srr_params.svh"
module srr_core_asserts
	import srr_pkg::*;
#(
	parameter int PC_WIDTH = 21,
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [PC_WIDTH-1:0] top_of_return_stack,
	input wire srr_shadow_type shadow_in,
	input wire logic extended_enable,
	input wire logic [ADDR_WIDTH-1:0] index_pointer,
	input wire logic [7:0] file_rd_data,
	input wire srr_phase_type phase_r,
	input wire logic flush_r,
	input wire logic stack_pop_r,
	input wire logic [PC_WIDTH-1:0] pc_r,
	input wire logic [7:0] working_r,
	input wire logic [7:0] flags_r,
	input wire logic [3:0] bank_select_register_r,
	input wire logic [ADDR_WIDTH-1:0] file_rd_addr_r,
	input wire srr_file_wr_type file_wr_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [8:0] seen_r; // Operand and old carry, caught where the operand is read
	// Kept in the checker so result checks need no deep $past
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) seen_r <= 9'h000;
		else if (phase_r == SRR_Q3) seen_r <= {file_rd_data, flags_r[`SRR_FLAG_C]};
	end
	// Instruction accepted at a Q1 edge outside a flush
	sequence ret_take;
		phase_r == SRR_Q1 && instr_valid && !flush_r && instr_word[15:1] == `SRR_RET_PATTERN;
	endsequence
	sequence rot_take;
		phase_r == SRR_Q1 && instr_valid && !flush_r && instr_word[15:10] == `SRR_ROT_PATTERN;
	endsequence
	a_ret_pc_load: assert property (ret_take |-> ##4 pc_r == $past(top_of_return_stack))
		else $error("pc not loaded from stack top");
	a_ret_pop_pulse: assert property (ret_take |-> ##3 !stack_pop_r ##1 stack_pop_r ##1 !stack_pop_r)
		else $error("stack pop not a single pulse");
	a_ret_shadow_load: assert property (ret_take ##0 instr_word[0] |->
		##4 {working_r, flags_r, bank_select_register_r} == $past(shadow_in))
		else $error("shadow copies not restored");
	a_ret_regs_kept: assert property (ret_take ##0 !instr_word[0] |->
		##1 ($stable({working_r, flags_r, bank_select_register_r}))[*4])
		else $error("plain return touched registers");
	a_ret_flush_len: assert property (ret_take |-> ##4 flush_r [*4] ##1 !flush_r)
		else $error("flush cycle wrong length");
	a_rot_flag_update: assert property (rot_take |-> ##4 flags_r[`SRR_FLAG_C] == seen_r[8] &&
		flags_r[`SRR_FLAG_N] == seen_r[7] && flags_r[`SRR_FLAG_Z] == (seen_r[7:0] == 8'h00))
		else $error("rotate flags wrong");
	a_rot_to_working: assert property (rot_take ##0 !instr_word[`SRR_DEST_BIT] |->
		##1 (!file_wr_r.we) [*4] ##0 working_r == seen_r[7:0])
		else $error("rotate into working wrong");
	a_rot_write_back: assert property (rot_take ##0 instr_word[`SRR_DEST_BIT] |-> ##4
		file_wr_r.we && file_wr_r.data == seen_r[7:0] && file_wr_r.addr == file_rd_addr_r
		&& $stable(working_r))
		else $error("rotate write back wrong");
	a_rot_index_addr: assert property (rot_take ##0 (!instr_word[`SRR_ACC_BIT] &&
		instr_word[7:0] <= `SRR_IDX_LIMIT) ##1 extended_enable |=>
		file_rd_addr_r == $past(index_pointer) + ADDR_WIDTH'($past(instr_word[7:0], 2)))
		else $error("indexed operand address wrong");
endmodule : srr_core_asserts
bind srr_core srr_core_asserts #(.PC_WIDTH(PC_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) u_chk (
	.clk(clk),
	.arst_n(arst_n),
	.instr_valid(instr_valid),
	.instr_word(instr_word),
	.top_of_return_stack(top_of_return_stack),
	.shadow_in(shadow_in),
	.extended_enable(extended_enable),
	.index_pointer(index_pointer),
	.file_rd_data(file_rd_data),
	.phase_r(phase_r),
	.flush_r(flush_r),
	.stack_pop_r(stack_pop_r),
	.pc_r(pc_r),
	.working_r(working_r),
	.flags_r(flags_r),
	.bank_select_register_r(bank_select_register_r),
	.file_rd_addr_r(file_rd_addr_r),
	.file_wr_r(file_wr_r)
);

// *** sim/test_subroutine_return_and_rotate_exec.sv ***
/* Self-checking bench for the return and rotate block.
 * Assumes the bench itself stands in for stack, shadows and file memory. */
`timescale 1ns/1ns
module test_subroutine_return_and_rotate_exec
	import srr_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr_word = 16'h0000;
	logic [20:0] top_of_return_stack = 21'h000000;
	srr_shadow_type shadow_in = '0;
	logic extended_enable = 1'b1; // Extended set on unless a test clears it
	logic [11:0] index_pointer = 12'h100;
	logic [7:0] file_rd_data = 8'h00;
	srr_phase_type phase_r;
	logic flush_r, stack_pop_r;
	logic [20:0] pc_r;
	logic [7:0] working_r, flags_r;
	logic [3:0] bank_select_register_r;
	logic [11:0] file_rd_addr_r;
	srr_file_wr_type file_wr_r;
	int error_cnt = 0;
	int n_compared = 0;
	logic cy = 1'b0; // Carry as the bench expects it
	srr_core DUT (
		.clk(clk),
		.arst_n(arst_n),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.top_of_return_stack(top_of_return_stack),
		.shadow_in(shadow_in),
		.extended_enable(extended_enable),
		.index_pointer(index_pointer),
		.file_rd_data(file_rd_data),
		.phase_r(phase_r),
		.flush_r(flush_r),
		.stack_pop_r(stack_pop_r),
		.pc_r(pc_r),
		.working_r(working_r),
		.flags_r(flags_r),
		.bank_select_register_r(bank_select_register_r),
		.file_rd_addr_r(file_rd_addr_r),
		.file_wr_r(file_wr_r)
	);
	always #10 clk = ~clk;
	// Compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Present a word so that the next Q1 edge takes it; returns at that edge
	task automatic issue(input logic [15:0] w, input logic [7:0] rd);
		@(negedge clk);
		while (phase_r !== SRR_Q4) @(negedge clk);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
		file_rd_data <= rd;
		@(posedge clk);
		instr_valid <= 1'b0;
	endtask : issue
	// Rotates alternating working and file: indexed, access-bank, banked, plain operands
	task automatic t_rotate;
		logic [7:0] d [6] = '{8'hE6, 8'h80, 8'h00, 8'h80, 8'h01, 8'h7F};
		logic [7:0] f, res;
		logic [11:0] adr;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			extended_enable <= (i != 5); // Last rotate runs without the extended set
			f = i[1] ? 8'h60 : 8'h10;
			if (i == 4 || i == 5) adr = {4'h0, f}; // Bank is still zero from reset
			else adr = (f <= 8'h5F) ? index_pointer + {4'h0, f} : {4'hF, f};
			res = {d[i][6:0], cy};
			cy = d[i][7];
			issue({6'h0D, i[0], i == 4, f}, d[i]);
			repeat (3) @(posedge clk);
			#1;
			chk(file_rd_addr_r, adr, "operand address");
			if (i[0]) chk(file_wr_r, {1'b1, adr, res}, "write back");
			else chk({file_wr_r.we, working_r}, {1'b0, res}, "working result");
			chk(flags_r, {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, cy}, "flags");
			chk(phase_r, SRR_Q1, "phase after write");
		end
		$display("rotate test done");
	endtask : t_rotate
	// Plain and fast return, each with a word offered during the flush
	task automatic t_return;
		logic [19:0] exp;
		for (int s = 0; s < 2; s++) begin
			exp = s[0] ? 20'h5AA59 : {working_r, flags_r, bank_select_register_r};
			@(posedge clk);
			top_of_return_stack <= {20'h0D5E0, s[0]};
			shadow_in <= 20'h5AA59;
			issue({15'h0009, s[0]}, 8'hFF);
			@(posedge clk);
			instr_valid <= 1'b1;
			instr_word <= 16'h3410; // Rotate into working, must be ignored
			repeat (2) @(posedge clk);
			#1;
			chk({stack_pop_r, pc_r}, {1'b1, 20'h0D5E0, s[0]}, "pop and pc");
			chk({working_r, flags_r, bank_select_register_r}, exp, "regs");
			chk(flush_r, 1'b1, "flush");
			repeat (2) @(posedge clk);
			instr_valid <= 1'b0;
			repeat (4) @(posedge clk);
			#1;
			chk({flush_r, stack_pop_r, working_r}, {2'b00, exp[19:12]}, "after flush");
		end
		$display("return test done");
	endtask : t_return
	// Verdict and end of run
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_rotate();
		t_return();
		tally_and_finish();
	end
	// Watchdog at 5000 cycles, far beyond the fewer than 100 cycles needed
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : test_subroutine_return_and_rotate_exec

// *** src/srr_core.sv ***
/*
 * Execution of the subroutine return and rotate-left-through-carry
 * instructions, paced by a four-phase instruction cycle.
 * Assumes: the instruction word, stack top, shadow copies, file read data
 * and index pointer come from logic on the same clock; the return stack
 * pops on the one-cycle pop strobe; file read data is valid one clock
 * after the read address is shown.
 */
// Function
// (RQ1) Return pops stack, top value loads program counter
// (RQ2) Select one restores working, flags, bank from shadows
// (RQ3) Select zero leaves working, flags, bank alone
// (RQ4) Return keeps pc latches and arithmetic flags
// (RQ5) Rotate left; old top to carry, carry in
// (RQ6) Destination zero writes working, file untouched
// (RQ7) Destination one writes back the file register
// (RQ8) Indexed offset addressing when extended and f<=95
// (RQ9) Return two cycles with flush; rotate one
// (RQ10) Rotate sets carry, negative, zero from result
`timescale 1ns/1ns
`include "srr_params.svh"
module srr_core
	import srr_pkg::*;
#(
	parameter int PC_WIDTH = 21,
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [PC_WIDTH-1:0] top_of_return_stack,
	input wire srr_shadow_type shadow_in,
	input wire logic extended_enable,
	input wire logic [ADDR_WIDTH-1:0] index_pointer,
	input wire logic [7:0] file_rd_data,
	output srr_phase_type phase_r,
	output logic flush_r,
	output logic stack_pop_r,
	output logic [PC_WIDTH-1:0] pc_r,
	output logic [7:0] working_r,
	output logic [7:0] flags_r,
	output logic [3:0] bank_select_register_r,
	output logic [ADDR_WIDTH-1:0] file_rd_addr_r,
	output srr_file_wr_type file_wr_r
);
	// Phase and operation state
	srr_phase_type phase_nxt;
	srr_op_type op_r; // Operation of the current instruction cycle
	srr_op_type op_nxt;
	logic [15:0] instr_r; // Word latched at decode
	logic [15:0] instr_nxt;
	logic [7:0] operand_r; // File value captured at Q3
	logic [7:0] operand_nxt;
	logic flush_nxt;
	logic stack_pop_nxt;
	logic [PC_WIDTH-1:0] pc_nxt;
	logic [7:0] working_nxt;
	logic [7:0] flags_nxt;
	logic [3:0] bank_nxt;
	logic [ADDR_WIDTH-1:0] rd_addr_nxt;
	srr_file_wr_type file_wr_nxt;

	// Rotate datapath outputs
	logic [7:0] rot_result;
	logic rot_carry;
	logic rot_neg;
	logic rot_zero;

	// Effective file address of the operand
	function automatic logic [ADDR_WIDTH-1:0] operand_addr(
		input logic [15:0] word,
		input logic ext,
		input logic [ADDR_WIDTH-1:0] ptr,
		input logic [3:0] bank
	);
		logic [7:0] f;
		logic [ADDR_WIDTH-1:0] result;
		f = word[`SRR_FILE_MSB:`SRR_FILE_LSB];
		result = '0;
		if (word[`SRR_ACC_BIT]) begin
			// Banked access
			result = ADDR_WIDTH'({bank, f});
		end else if (f <= `SRR_IDX_LIMIT) begin
			// Low access region, or pointer plus literal offset
			if (ext) begin
				result = ptr + ADDR_WIDTH'(f); // RQ8
			end else begin
				result = ADDR_WIDTH'(f);
			end
		end else begin
			// Upper access region maps onto the special function bank
			result = ADDR_WIDTH'({`SRR_ACCESS_HIGH_BANK, f});
		end
		return result;
	endfunction : operand_addr

	// Decode helpers
	function automatic logic is_return(input logic [15:0] word);
		return word[`SRR_RET_OP_MSB:`SRR_RET_OP_LSB] == `SRR_RET_PATTERN;
	endfunction : is_return

	function automatic logic is_rotate(input logic [15:0] word);
		return word[`SRR_ROT_OP_MSB:`SRR_ROT_OP_LSB] == `SRR_ROT_PATTERN;
	endfunction : is_rotate

	// Rotate with the carry held in the flags register
	srr_rot #(
		.WIDTH(8)
	) u_rot (
		.operand(operand_r),
		.carry_in(flags_r[`SRR_FLAG_C]),
		.result(rot_result),
		.carry_out(rot_carry),
		.negative(rot_neg),
		.zero(rot_zero)
	);

	// Next-state for phases, decode and the architectural registers
	always_comb begin
		phase_nxt = phase_r;
		op_nxt = op_r;
		instr_nxt = instr_r;
		operand_nxt = operand_r;
		flush_nxt = flush_r;
		stack_pop_nxt = 1'b0;
		pc_nxt = pc_r;
		working_nxt = working_r;
		flags_nxt = flags_r;
		bank_nxt = bank_select_register_r;
		rd_addr_nxt = file_rd_addr_r;
		file_wr_nxt = file_wr_r;
		file_wr_nxt.we = 1'b0;
		case (phase_r)
			SRR_Q1: begin
				// Decode; a flush cycle swallows its word
				phase_nxt = SRR_Q2;
				instr_nxt = instr_word;
				if (op_r == SRR_OP_FLUSH) begin
					op_nxt = SRR_OP_FLUSH; // RQ9
				end else if (instr_valid && is_return(instr_word)) begin
					op_nxt = SRR_OP_RET;
				end else if (instr_valid && is_rotate(instr_word)) begin
					op_nxt = SRR_OP_ROT;
				end else begin
					op_nxt = SRR_OP_NONE;
				end
			end
			SRR_Q2: begin
				// Read register f
				phase_nxt = SRR_Q3;
				if (op_r == SRR_OP_ROT) begin
					rd_addr_nxt = operand_addr(instr_r, extended_enable, index_pointer,
						bank_select_register_r); // RQ8
				end
			end
			SRR_Q3: begin
				// Process: capture the operand read in Q2
				phase_nxt = SRR_Q4;
				if (op_r == SRR_OP_ROT) begin
					operand_nxt = file_rd_data;
				end
			end
			SRR_Q4: begin
				// Write destination, or pop into the program counter
				phase_nxt = SRR_Q1;
				case (op_r)
					SRR_OP_RET: begin // RQ4
						pc_nxt = top_of_return_stack; // RQ1
						stack_pop_nxt = 1'b1; // RQ1
						if (instr_r[`SRR_SEL_BIT]) begin // RQ3
							// Fast return: whole flags byte from its shadow
							working_nxt = shadow_in.working; // RQ2
							flags_nxt = shadow_in.flags; // RQ2
							bank_nxt = shadow_in.bank; // RQ2
						end
						// Select clear keeps working, flags, bank
						// No latch state here and no flag arithmetic
						op_nxt = SRR_OP_FLUSH; // RQ9
						flush_nxt = 1'b1; // RQ9
					end
					SRR_OP_ROT: begin
						flags_nxt[`SRR_FLAG_C] = rot_carry; // RQ10
						flags_nxt[`SRR_FLAG_N] = rot_neg; // RQ10
						flags_nxt[`SRR_FLAG_Z] = rot_zero; // RQ10
						if (instr_r[`SRR_DEST_BIT]) begin
							file_wr_nxt.we = 1'b1; // RQ7
							file_wr_nxt.addr = file_rd_addr_r; // RQ7
							file_wr_nxt.data = rot_result; // RQ7
						end else begin
							working_nxt = rot_result; // RQ6
						end
						op_nxt = SRR_OP_NONE;
					end
					SRR_OP_FLUSH: begin
						// Flush cycle done, next cycle executes
						op_nxt = SRR_OP_NONE;
						flush_nxt = 1'b0; // RQ9
					end
					default: begin
						op_nxt = SRR_OP_NONE;
					end
				endcase
			end
			default: begin
				// Illegal phase code recovers to decode
				phase_nxt = SRR_Q1;
				op_nxt = SRR_OP_NONE;
			end
		endcase
	end

	// Registers only; every output comes from here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= SRR_Q1;
			op_r <= SRR_OP_NONE;
			instr_r <= `SRR_INSTR_RESET;
			operand_r <= `SRR_BYTE_RESET;
			flush_r <= 1'b0;
			stack_pop_r <= 1'b0;
			pc_r <= `SRR_PC_RESET;
			working_r <= `SRR_BYTE_RESET;
			flags_r <= `SRR_BYTE_RESET;
			bank_select_register_r <= `SRR_BSR_RESET;
			file_rd_addr_r <= `SRR_ADDR_RESET;
			file_wr_r <= '0;
		end else begin
			phase_r <= phase_nxt;
			op_r <= op_nxt;
			instr_r <= instr_nxt;
			operand_r <= operand_nxt;
			flush_r <= flush_nxt;
			stack_pop_r <= stack_pop_nxt;
			pc_r <= pc_nxt;
			working_r <= working_nxt;
			flags_r <= flags_nxt;
			bank_select_register_r <= bank_nxt;
			file_rd_addr_r <= rd_addr_nxt;
			file_wr_r <= file_wr_nxt;
		end
	end
endmodule : srr_core

// *** src/srr_rot.sv ***
/*
 * Rotate-left-through-carry datapath with the flags derived from its result.
 * Purely combinational; assumes the caller registers everything it keeps.
 */
`timescale 1ns/1ns
module srr_rot #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] operand,
	input wire logic carry_in,
	output logic [WIDTH-1:0] result,
	output logic carry_out,
	output logic negative,
	output logic zero
);
	// Old top bit leaves into carry, old carry enters bit zero
	always_comb begin
		result = {operand[WIDTH-2:0], carry_in}; // RQ5
		carry_out = operand[WIDTH-1]; // RQ5
		negative = result[WIDTH-1]; // RQ10
		zero = (result == '0); // RQ10
	end
endmodule : srr_rot
